// [shared/wdg_defines.svh]
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH

// Register byte offsets on the APB
`define WDG_CTRL_OFFSET      12'h000
`define WDG_STAT_OFFSET      12'h004

// Control register field positions
`define WDG_UNLOCK_BIT       4
`define WDG_ON_BIT           3
`define WDG_TSEL_MSB         2
`define WDG_TSEL_LSB         0

// Status register field positions
`define WDG_STAT_LVL_MSB     1
`define WDG_STAT_LVL_LSB     0
`define WDG_STAT_WIN_BIT     2
`define WDG_STAT_ON_BIT      3

// Reset values
`define WDG_ON_RST           1'b0
`define WDG_TSEL_RST         3'h0

// Change window length in system clock cycles
`define WDG_UNLOCK_CYCLES    3'h4

// Time-out is 2**(base + select) oscillator ticks
`define WDG_TIMEOUT_BASE_LOG2 14

`endif

// [shared/wdg_pkg.sv]
package wdg_pkg;

   typedef enum logic [1:0] {
      LVL_0,
      LVL_1,
      LVL_2
   } prot_level_e;

   // Guard state, one flop set for the top module except its time-out counter
   typedef struct packed {
      logic [1:0]  fuse_s1;
      logic [1:0]  fuse_s2;
      logic        tick_s1;
      logic        tick_s2;
      logic        tick_s3;
      logic        on;
      logic [2:0]  tsel;
      logic [2:0]  win_cnt;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        wdt_reset;
   } guard_state_s;

endpackage : wdg_pkg

// [verilog/wdg_timeout_counter.sv]
`timescale 1ns/1ps
`include "wdg_defines.svh"

module wdg_timeout_counter #(
   parameter int BASE_LOG2 = `WDG_TIMEOUT_BASE_LOG2
) (
   input  wire logic       i_clock,
   input  wire logic       i_rst_b,
   input  wire logic       i_tick,
   input  wire logic       i_enable,
   input  wire logic       i_kick,
   input  wire logic [2:0] i_tsel,
   output logic            o_expired
);

   localparam int CW = BASE_LOG2 + 8;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          expired;
   } cnt_state_s;

   cnt_state_s st_ff;
   cnt_state_s nxt_st;
   logic [CW-1:0] limit;

   // Terminal count of 2**(base + select) - 1 ticks
   assign limit = ({{(CW-1){1'b0}}, 1'b1} << (BASE_LOG2 + int'(i_tsel))) - 1'b1;

   // Disabled or kicked counter restarts from zero
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.expired = 1'b0;
      if (!i_enable || i_kick) begin
         nxt_st.cnt = '0;
      end else if (i_tick) begin
         if (st_ff.cnt >= limit) begin
            nxt_st.cnt     = '0;
            nxt_st.expired = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_expired = st_ff.expired;

endmodule : wdg_timeout_counter

// [verilog/watchdog_config_guard.sv]
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "wdg_defines.svh"

// Functional notes
// - Level 0: starts off, enable by one write
// - Level 0: time-out field writable any time
// - Levels 0/1: second write applies enable, time-out
// - Level 1: starts off, enable needs no unlock
// - Level 1: disable or time-out change needs unlock
// - Level 2: always running, enable reads one
// - Level 2: only unlock-plus-enable opens window
// - Level 2: second write changes time-out only
// - Unlock bit self-clears after four cycles
// - Level from compat and always-on fuses
// - Time-out is 2**(14+select) oscillator cycles
// - Elapsed unkicked time-out issues chip reset
module watchdog_config_guard
   import wdg_pkg::*;
#(
   parameter int TIMEOUT_BASE_LOG2 = `WDG_TIMEOUT_BASE_LOG2
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic        i_compat_level_fuse,
   input  wire logic        i_always_on_fuse,
   input  wire logic        i_wdt_osc_tick,
   input  wire logic        i_kick_instruction,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic             o_watchdog_on,
   output logic             o_wdt_reset
);

   guard_state_s st_ff;
   guard_state_s nxt_st;

   prot_level_e  lvl;
   logic         commit;
   logic         ctrl_sel;
   logic         stat_sel;
   logic         ctrl_wr;
   logic         wr_unlock;
   logic         wr_on;
   logic [2:0]   wr_tsel;
   logic         win_open;
   logic         open_wr;
   logic         second_wr;
   logic         tick;
   logic         expired;

   // Address decode, used for both reads and writes
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offs);
      addr_hit = (addr[11:2] == offs[11:2]);
   endfunction : addr_hit

   // Level from the synchronised fuses; always-on wins over compat
   always_comb begin
      if (st_ff.fuse_s2[1]) begin
         lvl = LVL_2;
      end else if (st_ff.fuse_s2[0]) begin
         lvl = LVL_0;
      end else begin
         lvl = LVL_1;
      end
   end

   // A transfer takes effect only at the edge that samples pready
   assign commit    = i_psel && i_penable && st_ff.pready;
   assign ctrl_sel  = addr_hit(i_paddr, `WDG_CTRL_OFFSET);
   assign stat_sel  = addr_hit(i_paddr, `WDG_STAT_OFFSET);
   assign ctrl_wr   = commit && i_pwrite && ctrl_sel;
   assign wr_unlock = i_pwdata[`WDG_UNLOCK_BIT];
   assign wr_on     = i_pwdata[`WDG_ON_BIT];
   assign wr_tsel   = i_pwdata[`WDG_TSEL_MSB:`WDG_TSEL_LSB];
   assign win_open  = (st_ff.win_cnt != 3'h0);

   // Only unlock plus enable in one write opens the window
   assign open_wr   = ctrl_wr && wr_unlock && wr_on;
   assign second_wr = ctrl_wr && !wr_unlock && win_open;

   // Oscillator tick edge, read only from the second sync stage on
   assign tick = st_ff.tick_s2 && !st_ff.tick_s3;

   // Whole next-state computation
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.fuse_s1 = {i_always_on_fuse, i_compat_level_fuse};
      nxt_st.fuse_s2 = st_ff.fuse_s1;
      nxt_st.tick_s1 = i_wdt_osc_tick;
      nxt_st.tick_s2 = st_ff.tick_s1;
      nxt_st.tick_s3 = st_ff.tick_s2;

      // Window countdown; reaching zero clears the unlock bit
      if (win_open) begin
         nxt_st.win_cnt = st_ff.win_cnt - 3'h1;
      end

      // Control register write policy per protection level
      if (open_wr) begin
         nxt_st.win_cnt = `WDG_UNLOCK_CYCLES;
         nxt_st.on      = 1'b1;
         if (lvl == LVL_0) begin
            nxt_st.tsel = wr_tsel;
         end
      end else if (second_wr) begin
         nxt_st.win_cnt = 3'h0;
         nxt_st.tsel    = wr_tsel;
         if (lvl != LVL_2) begin
            nxt_st.on = wr_on;
         end
      end else if (ctrl_wr) begin
         // Outside the window enabling is free, disabling is ignored
         nxt_st.on = st_ff.on || wr_on;
         if (lvl == LVL_0) begin
            nxt_st.tsel = wr_tsel;
         end
      end

      // Level 2 forces the watchdog on whatever was written
      if (lvl == LVL_2) begin
         nxt_st.on = 1'b1;
      end

      // APB: one wait state, answer and data from flops
      nxt_st.pready  = i_psel && i_penable && !st_ff.pready;
      nxt_st.pslverr = 1'b0;
      if (i_psel && i_penable && !st_ff.pready) begin
         nxt_st.prdata  = 32'h0;
         nxt_st.pslverr = !(ctrl_sel || stat_sel);
         if (!i_pwrite && ctrl_sel) begin
            nxt_st.prdata[`WDG_UNLOCK_BIT]              = win_open;
            nxt_st.prdata[`WDG_ON_BIT]                  = st_ff.on || (lvl == LVL_2);
            nxt_st.prdata[`WDG_TSEL_MSB:`WDG_TSEL_LSB] = st_ff.tsel;
         end else if (!i_pwrite && stat_sel) begin
            nxt_st.prdata[`WDG_STAT_LVL_MSB:`WDG_STAT_LVL_LSB] = lvl;
            nxt_st.prdata[`WDG_STAT_WIN_BIT]                  = win_open;
            nxt_st.prdata[`WDG_STAT_ON_BIT]                   = st_ff.on;
         end
      end

      // Chip reset request held one cycle per expiry
      nxt_st.wdt_reset = expired;
   end

   // Async reset: watchdog off, window shut, time-out at shortest
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_ff         <= '0;
         st_ff.on      <= `WDG_ON_RST;
         st_ff.tsel    <= `WDG_TSEL_RST;
         st_ff.win_cnt <= 3'h0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Counter restarts on kick, and whenever the watchdog is off
   wdg_timeout_counter #(
      .BASE_LOG2 (TIMEOUT_BASE_LOG2)
   ) u_counter (
      .i_clock   (i_clock),
      .i_rst_b   (i_rst_b),
      .i_tick    (tick),
      .i_enable  (st_ff.on),
      .i_kick    (i_kick_instruction),
      .i_tsel    (st_ff.tsel),
      .o_expired (expired)
   );

   assign o_prdata      = st_ff.prdata;
   assign o_pready      = st_ff.pready;
   assign o_pslverr     = st_ff.pslverr;
   assign o_watchdog_on = st_ff.on;
   assign o_wdt_reset   = st_ff.wdt_reset;

   // Checks on the guard behaviour
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   sequence s_open;
      open_wr;
   endsequence

   sequence s_quiet4;
      (!ctrl_wr) [*4];
   endsequence

   sequence s_lvl2_second;
      (lvl == LVL_2) && second_wr;
   endsequence

   lvl0_enable_a: assert property (
      (lvl == LVL_0) && ctrl_wr && wr_on |=> o_watchdog_on)
      else $error("Level 0 enable write did not turn watchdog on");

   lvl0_tsel_a: assert property (
      (lvl == LVL_0) && ctrl_wr |=> st_ff.tsel == $past(wr_tsel))
      else $error("Level 0 time-out write not applied");

   unlock_second_a: assert property (
      (lvl != LVL_2) && second_wr |=> (o_watchdog_on == $past(wr_on))
         && (st_ff.tsel == $past(wr_tsel)) && !win_open)
      else $error("Second write of unlock not applied");

   lvl1_guard_a: assert property (
      (lvl == LVL_1) && ctrl_wr && !win_open && !open_wr
         |=> $stable(st_ff.tsel) && (o_watchdog_on == ($past(o_watchdog_on) || $past(wr_on))))
      else $error("Level 1 change accepted without unlock");

   lvl2_on_a: assert property (
      (lvl == LVL_2) |=> o_watchdog_on)
      else $error("Level 2 watchdog not forced on");

   open_only_a: assert property (
      ctrl_wr && !(wr_unlock && wr_on) && !win_open |=> !win_open)
      else $error("Window opened by wrong first write");

   lvl2_tsel_a: assert property (
      s_lvl2_second |=> (st_ff.tsel == $past(wr_tsel)) && o_watchdog_on)
      else $error("Level 2 second write mishandled");

   win_close_a: assert property (
      s_open ##1 s_quiet4 |=> !win_open)
      else $error("Change window did not close after four cycles");

   win_start_a: assert property (
      s_open |=> st_ff.win_cnt == `WDG_UNLOCK_CYCLES)
      else $error("Change window not started at opening edge");

   // Pin to level through both sync stages, not just the decode
   fuse_lvl_a: assert property (
      $past(i_always_on_fuse, 2) && $past(i_rst_b, 2) && $past(i_rst_b)
         |-> lvl == LVL_2)
      else $error("Always-on fuse did not select level 2");

   fuse_lvl0_a: assert property (
      $past(i_compat_level_fuse, 2) && !$past(i_always_on_fuse, 2) && $past(i_rst_b, 2)
         && $past(i_rst_b) |-> lvl == LVL_0)
      else $error("Compat fuse alone did not select level 0");

   reset_out_a: assert property (
      expired |=> o_wdt_reset ##1 !o_wdt_reset)
      else $error("Expiry did not raise one-cycle chip reset");

endmodule : watchdog_config_guard

// [bench/watchdog_config_guard_tb.sv]
`timescale 1ns/1ps
module watchdog_config_guard_tb;
   localparam logic [11:0] CTRL = 12'h000;
   localparam logic [11:0] STAT = 12'h004;
   logic        i_clock, i_rst_b, i_psel, i_penable, i_pwrite;
   logic        i_compat_level_fuse, i_always_on_fuse;
   logic        i_wdt_osc_tick, i_kick_instruction;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic        o_pready, o_pslverr, o_watchdog_on, o_wdt_reset, er;
   int          n_errors, n_tests, pulses;

   // Short base keeps the time-out at 4..512 ticks
   watchdog_config_guard #(.TIMEOUT_BASE_LOG2(2)) dut (
      .i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .i_compat_level_fuse, .i_always_on_fuse, .i_wdt_osc_tick, .i_kick_instruction,
      .o_prdata, .o_pready, .o_pslverr, .o_watchdog_on, .o_wdt_reset);

   // 200 MHz system clock
   always #2.5 i_clock = ~i_clock;

   task summarize;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   // One APB transfer; psel stays up so a setup may follow at once
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clock);
         if (o_pready === 1'b1) break;
      end
      if (k == 20) begin
         n_errors++;
         $display("[ERR] %0t no pready within bound", $time);
         summarize();
      end
      rd = o_prdata;
      er = o_pslverr;
      i_penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk

   task idle(input int n);
      i_psel <= 1'b0;
      repeat (n) @(posedge i_clock);
   endtask : idle

   // Fuses settle two edges after release, so wait three
   // First edge of the run plus 15 here gives 16 edges in reset
   task do_reset(input logic c, input logic a);
      i_psel <= 1'b0;
      i_rst_b <= 1'b0;
      i_compat_level_fuse <= c;
      i_always_on_fuse <= a;
      repeat (15) @(posedge i_clock);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clock);
   endtask : do_reset

   // Slow oscillator: 4 high, 6 low per tick, counting reset pulses
   task ticks(input int n);
      pulses = 0;
      for (int i = 0; i < 10 * n; i++) begin
         i_wdt_osc_tick <= ((i % 10) < 4);
         @(posedge i_clock);
         if (o_wdt_reset === 1'b1) pulses++;
      end
   endtask : ticks

   task kick;
      i_kick_instruction <= 1'b1;
      @(posedge i_clock);
      i_kick_instruction <= 1'b0;
   endtask : kick

   task t_lvl0;
      do_reset(1'b1, 1'b0);
      rdchk(CTRL, 32'h0);
      rdchk(STAT, 32'h0);
      wr(CTRL, 32'h8);
      idle(1);
      check(32'(o_watchdog_on), 32'h1);
      wr(CTRL, 32'hd);
      rdchk(CTRL, 32'hd);
      wr(CTRL, 32'h0);
      rdchk(CTRL, 32'h8);
      wr(CTRL, 32'h18);
      wr(CTRL, 32'h3);
      rdchk(CTRL, 32'h3);
      idle(1);
      check(32'(o_watchdog_on), 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      check({rd[30:0], er}, 32'h1);
      idle(1);
      $display("level 0 test done");
   endtask : t_lvl0

   task t_lvl1;
      do_reset(1'b0, 1'b0);
      rdchk(STAT, 32'h1);
      rdchk(CTRL, 32'h0);
      wr(CTRL, 32'h8);
      rdchk(CTRL, 32'h8);
      wr(CTRL, 32'h5);
      rdchk(CTRL, 32'h8);
      wr(CTRL, 32'h18);
      rdchk(CTRL, 32'h18);
      wr(CTRL, 32'h5);
      rdchk(CTRL, 32'h8);
      wr(CTRL, 32'h18);
      idle(1);
      wr(CTRL, 32'h3);
      rdchk(CTRL, 32'h3);
      wr(CTRL, 32'h18);
      idle(2);
      wr(CTRL, 32'h5);
      rdchk(CTRL, 32'hb);
      wr(CTRL, 32'h10);
      wr(CTRL, 32'h0);
      rdchk(CTRL, 32'hb);
      idle(1);
      $display("level 1 test done");
   endtask : t_lvl1

   task t_lvl2;
      do_reset(1'b0, 1'b1);
      rdchk(CTRL, 32'h8);
      idle(1);
      check(32'(o_watchdog_on), 32'h1);
      wr(CTRL, 32'h0);
      rdchk(CTRL, 32'h8);
      wr(CTRL, 32'h10);
      wr(CTRL, 32'h2);
      rdchk(CTRL, 32'h8);
      wr(CTRL, 32'h18);
      wr(CTRL, 32'h4);
      rdchk(CTRL, 32'hc);
      do_reset(1'b1, 1'b1);
      apb(1'b0, STAT, 32'h0);
      check(32'(rd[1:0]), 32'h2);
      idle(1);
      $display("level 2 test done");
   endtask : t_lvl2

   task t_tmo;
      do_reset(1'b1, 1'b0);
      wr(CTRL, 32'h8);
      idle(1);
      ticks(3);
      check(32'(pulses), 32'h0);
      ticks(1);
      check(32'(pulses), 32'h1);
      ticks(3);
      kick();
      ticks(3);
      check(32'(pulses), 32'h0);
      ticks(1);
      wr(CTRL, 32'h9);
      idle(1);
      ticks(7);
      check(32'(pulses), 32'h0);
      ticks(1);
      check(32'(pulses), 32'h1);
      wr(CTRL, 32'h18);
      wr(CTRL, 32'h1);
      idle(1);
      ticks(8);
      check(32'(pulses), 32'h0);
      $display("time-out test done");
   endtask : t_tmo

   // Everything gets a value at time zero
   initial begin
      i_clock = 1'b0;
      i_rst_b = 1'b0;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 12'h0;
      i_pwdata = 32'h0;
      i_compat_level_fuse = 1'b0;
      i_always_on_fuse = 1'b0;
      i_wdt_osc_tick = 1'b0;
      i_kick_instruction = 1'b0;
      @(posedge i_clock);
      t_lvl0();
      t_lvl1();
      t_lvl2();
      t_tmo();
      summarize();
   end
endmodule : watchdog_config_guard_tb
